// ===== design/fm_pkg.sv
package fm_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int OC_DEG_STEP_NS = 200;
	localparam int OC_DEG_STEP_CYC =
		(OC_DEG_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LCK_DEG_STEP_NS = 1000;
	localparam int LCK_DEG_STEP_CYC =
		(LCK_DEG_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OC_RETRY_STEP_US = 500;
	localparam int OC_RETRY_STEP_CYC = OC_RETRY_STEP_US * 1000 / CLK_PERIOD_NS;
	localparam int STALL_RETRY_TIME_STEP_MS = 100;
	localparam int STALL_RETRY_TIME_STEP_CYC =
		STALL_RETRY_TIME_STEP_MS * 1000000 / CLK_PERIOD_NS;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_CFG = 5'h04;
	localparam logic [4:0] ADDR_LVL = 5'h08;
	localparam logic [4:0] ADDR_STAT = 5'h0c;
	localparam logic [11:0] CTRL_RESET = 12'h000;
	localparam logic [31:0] CFG_RESET = 32'h00000000;
	localparam logic [11:0] LVL_RESET = 12'hfff;
	localparam logic [31:0] CFG_MASK = 32'h00ffffff;
	// ctrl fields
	localparam int C_OVERVOLT_PROTECT_EN = 0;
	localparam int C_OVERVOLT_LEVEL_SEL = 1;
	localparam int C_OC_MODE = 2;
	localparam int C_CBC_MODE = 4;
	localparam int C_LCK_MODE = 8;
	localparam int C_CLEAR = 12;
	// cfg fields
	localparam int F_OC_LVL = 0;
	localparam int F_OC_DEG = 4;
	localparam int F_OC_RETRY = 6;
	localparam int F_CBC_LVL = 8;
	localparam int F_OL_LVL = 12;
	localparam int F_CBC_HOLD = 16;
	localparam int F_LCK_DEG = 19;
	localparam int F_STALL_RETRY_TIME = 21;
	// modes
	localparam logic [1:0] OC_LATCH = 2'h0;
	localparam logic [1:0] OC_RETRY = 2'h1;
	localparam logic [1:0] OC_REPORT = 2'h2;
	localparam logic [1:0] OC_OFF = 2'h3;
	localparam logic [1:0] CBC_NEXT = 2'h0;
	localparam logic [1:0] CBC_THR = 2'h1;
	localparam logic [1:0] CBC_CNT = 2'h2;
	localparam logic [3:0] CBC_REPORT = 4'h6;
	localparam logic [1:0] LCK_LATCH = 2'h0;
	localparam logic [1:0] LCK_AUTO = 2'h1;
	localparam logic [3:0] LCK_REPORT = 4'h8;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		BR_RUN = 3'h0,
		BR_RECIRC = 3'h1,
		BR_HS_BRAKE = 3'h3,
		BR_LS_BRAKE = 3'h2,
		BR_OFF = 3'h6
	} fm_bridge_e;

	// (sel + 1) steps of the given unit
	function automatic logic [31:0] fm_steps(input logic [2:0] sel,
		input logic [31:0] unit);
		return unit * ({29'h0, sel} + 32'h1);
	endfunction
endpackage

// ===== design/fm_sync.sv
`timescale 1ns/100ps
module fm_sync
	import fm_pkg::*;
#(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} fm_sync_s;

	fm_sync_s s_reg;
	fm_sync_s s_next;

	// a bit moves only when the last two stages agree
	always_comb begin
		s_next = s_reg;
		s_next.s1 = d;
		s_next.s2 = s_reg.s1;
		s_next.s3 = s_reg.s2;
		s_next.q = (s_reg.s2 & ~(s_reg.s2 ^ s_reg.s3)) |
			(s_reg.q & (s_reg.s2 ^ s_reg.s3));
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign q = s_reg.q;
endmodule

// ===== design/fm_deglitch.sv
`timescale 1ns/100ps
module fm_deglitch
	import fm_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// level and required length in cycles
	input wire logic level,
	input wire logic [7:0] limit,
	output logic det
);
	typedef struct packed {
		logic [7:0] cnt;
		logic det;
	} fm_deg_s;

	fm_deg_s s_reg;
	fm_deg_s s_next;

	// any drop restarts the count, so only an unbroken run fires
	always_comb begin
		s_next = s_reg;
		if (!level) begin
			s_next.cnt = 8'h00;
			s_next.det = 1'b0;
		end else if (s_reg.cnt >= limit) begin
			s_next.det = 1'b1;
		end else begin
			s_next.cnt = s_reg.cnt + 8'h01;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign det = s_reg.det;
endmodule

// ===== design/fm_fault_mgr.sv
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module fm_fault_mgr
	import fm_pkg::*;
#(
	parameter logic [31:0] OC_RETRY_CYC = OC_RETRY_STEP_CYC,
	parameter logic [31:0] STALL_RETRY_TIME_CYC = STALL_RETRY_TIME_STEP_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// analog event pins
	input wire logic motor_supply_undervolt,
	input wire logic analog_rail_undervolt,
	input wire logic buck_undervolt,
	input wire logic buck_overcurrent,
	input wire logic pump_undervolt_event,
	input wire logic overvolt_low_trip,
	input wire logic overvolt_high_trip,
	input wire logic [5:0] fet_overcurrent_cmp,
	input wire logic cycle_limit_cmp,
	// motor control side
	input wire logic pwm_cycle_start,
	input wire logic open_loop,
	input wire logic [11:0] sense_amp_output,
	input wire logic sense_valid,
	// outputs to power stage
	output fm_bridge_e bridge_state,
	output logic fault_pin_n,
	output logic dev_reset_req,
	output logic pump_disable,
	output logic buck_disable,
	output logic overvolt_level_sel,
	output logic [3:0] overcurrent_level,
	output logic [3:0] cycle_limit_level,
	// axi4-lite slave
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef struct packed {
		logic [11:0] ctrl;
		logic [31:0] cfg;
		logic [11:0] lvl;
		logic clr;
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic sense_hi;
		logic drv_flag;
		logic pump_flag;
		logic ovp_flag;
		logic oc_flag;
		logic [5:0] oc_fet;
		logic oc_latch;
		logic oc_hold;
		logic [31:0] oc_timer;
		logic cbc_act;
		logic cbc_pin;
		logic cbc_rep;
		logic [2:0] cbc_cnt;
		logic lock_act;
		logic lock_retry;
		logic lock_flag;
		logic [31:0] lock_timer;
		fm_bridge_e bridge;
		logic fault_n;
		logic rst_req;
		logic pump_off;
		logic buck_off;
	} fm_state_s;

	localparam fm_state_s ST_RESET = '{
		ctrl: CTRL_RESET,
		cfg: CFG_RESET,
		lvl: LVL_RESET,
		bridge: BR_OFF,
		fault_n: 1'b1,
		default: '0
	};

	fm_state_s s_reg;
	fm_state_s s_next;

	// ------------------------------------------------------------
	// input conditioning
	// ------------------------------------------------------------
	logic [13:0] sync_q;
	logic motor_supply_undervolt_s;
	logic avdd_s;
	logic buck_uv_s;
	logic buck_oc_s;
	logic pump_uv;
	logic ov_low;
	logic ov_high;
	logic [5:0] fet_oc_s;
	logic cbc_cmp;
	logic [5:0] oc_det;
	logic buck_oc_det;
	logic lock_det;
	logic [7:0] oc_deg_cnt;
	logic [7:0] lck_deg_cnt;

	fm_sync #(.W(14)) u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.d({motor_supply_undervolt, analog_rail_undervolt, buck_undervolt,
			buck_overcurrent, pump_undervolt_event, overvolt_low_trip,
			overvolt_high_trip, fet_overcurrent_cmp, cycle_limit_cmp}),
		.q(sync_q)
	);

	assign {motor_supply_undervolt_s, avdd_s, buck_uv_s, buck_oc_s, pump_uv, ov_low, ov_high,
		fet_oc_s, cbc_cmp} = sync_q;

	assign oc_deg_cnt = 8'(fm_steps({1'b0, s_reg.cfg[F_OC_DEG +: 2]},
		OC_DEG_STEP_CYC));
	assign lck_deg_cnt = 8'(fm_steps({1'b0, s_reg.cfg[F_LCK_DEG +: 2]},
		LCK_DEG_STEP_CYC));

	// per-FET and buck comparators share the overcurrent deglitch
	for (genvar i = 0; i < 6; i++) begin : g_oc
		fm_deglitch u_deg (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.level(fet_oc_s[i]),
			.limit(oc_deg_cnt),
			.det(oc_det[i])
		);
	end

	fm_deglitch u_buck_deg (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.level(buck_oc_s),
		.limit(oc_deg_cnt),
		.det(buck_oc_det)
	);

	fm_deglitch u_lock_deg (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.level(s_reg.sense_hi),
		.limit(lck_deg_cnt),
		.det(lock_det)
	);

	// byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	logic sys_down;
	logic ov_now;
	logic oc_live;
	logic [1:0] oc_mode;
	logic [3:0] cbc_mode;
	logic [3:0] lck_mode;
	logic cbc_auto;
	logic [31:0] wm;

	always_comb begin
		s_next = s_reg;
		s_next.clr = 1'b0;
		oc_mode = s_reg.ctrl[C_OC_MODE +: 2];
		cbc_mode = s_reg.ctrl[C_CBC_MODE +: 4];
		lck_mode = s_reg.ctrl[C_LCK_MODE +: 4];
		wm = 32'h0;
		// ---------------- register bus ----------------
		if (s_axi_awvalid && s_reg.awready) begin
			s_next.aw_got = 1'b1;
			s_next.waddr = s_axi_awaddr[ADDR_W-1:0];
		end
		if (s_axi_wvalid && s_reg.wready) begin
			s_next.w_got = 1'b1;
			s_next.wdata = s_axi_wdata;
			s_next.wstrb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end
		if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
			s_next.aw_got = 1'b0;
			s_next.w_got = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = AXI_OKAY;
			unique case (s_reg.waddr)
				ADDR_CTRL: begin
					wm = merge({20'h0, s_reg.ctrl}, s_reg.wdata, s_reg.wstrb);
					s_next.ctrl = wm[11:0];
					s_next.clr = wm[C_CLEAR];
				end
				ADDR_CFG: begin
					s_next.cfg = merge(s_reg.cfg, s_reg.wdata, s_reg.wstrb) &
						CFG_MASK;
				end
				ADDR_LVL: begin
					wm = merge({20'h0, s_reg.lvl}, s_reg.wdata, s_reg.wstrb);
					s_next.lvl = wm[11:0];
				end
				ADDR_STAT: begin
				end
				default: begin
					s_next.bresp = AXI_SLVERR;
				end
			endcase
		end
		s_next.awready = !s_next.aw_got && !s_next.bvalid;
		s_next.wready = !s_next.w_got && !s_next.bvalid;
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_reg.arready) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = AXI_OKAY;
			unique case (s_axi_araddr[ADDR_W-1:0])
				ADDR_CTRL: s_next.rdata = {20'h0, s_reg.ctrl};
				ADDR_CFG: s_next.rdata = s_reg.cfg;
				ADDR_LVL: s_next.rdata = {20'h0, s_reg.lvl};
				ADDR_STAT: s_next.rdata = {19'h0, s_reg.lock_flag,
					s_reg.cbc_act | s_reg.cbc_rep, s_reg.oc_fet, s_reg.oc_flag,
					s_reg.ovp_flag, s_reg.pump_flag,
					s_reg.lock_flag | s_reg.cbc_pin | s_reg.cbc_rep,
					s_reg.drv_flag};
				default: begin
					s_next.rdata = 32'h0;
					s_next.rresp = AXI_SLVERR;
				end
			endcase
		end
		s_next.arready = !s_next.rvalid;
		if (sense_valid) begin
			s_next.sense_hi = sense_amp_output > s_reg.lvl;
		end
		// ---------------- driver faults ----------------
		ov_now = s_reg.ctrl[C_OVERVOLT_PROTECT_EN] &&
			(s_reg.ctrl[C_OVERVOLT_LEVEL_SEL] ? ov_high : ov_low);
		oc_live = oc_mode != OC_OFF && (|oc_det);
		// clears first so that a same-cycle event wins
		if (s_reg.clr) begin
			s_next.pump_flag = 1'b0;
			s_next.ovp_flag = 1'b0;
			if (!(|oc_det)) begin
				s_next.oc_flag = 1'b0;
				s_next.oc_fet = 6'h00;
				s_next.oc_latch = 1'b0;
			end
			if (!pump_uv && !ov_now && !oc_live) begin
				s_next.drv_flag = 1'b0;
			end
		end
		if (pump_uv) begin
			s_next.pump_flag = 1'b1;
		end
		if (ov_now) begin
			s_next.ovp_flag = 1'b1;
		end
		if (oc_live) begin
			s_next.oc_flag = 1'b1;
			s_next.oc_fet = s_reg.oc_fet | oc_det;
		end
		if (pump_uv || ov_now || oc_live) begin
			s_next.drv_flag = 1'b1;
		end
		if (oc_live && oc_mode == OC_LATCH) begin
			s_next.oc_latch = 1'b1;
		end
		if (s_reg.oc_hold) begin
			if (s_reg.oc_timer <= 32'h1) begin
				s_next.oc_hold = 1'b0;
			end else begin
				s_next.oc_timer = s_reg.oc_timer - 32'h1;
			end
		end else if (oc_live && oc_mode == OC_RETRY) begin
			s_next.oc_hold = 1'b1;
			s_next.oc_timer = fm_steps({1'b0, s_reg.cfg[F_OC_RETRY +: 2]},
				OC_RETRY_CYC);
		end
		// ---------------- cycle-by-cycle limit ----------------
		cbc_auto = !cbc_mode[3] && cbc_mode[2:1] != 2'b11;
		if (s_reg.cbc_act) begin
			if (!cbc_auto) begin
				s_next.cbc_act = 1'b0;
			end else begin
				unique case (cbc_mode[2:1])
					CBC_NEXT: begin
						if (pwm_cycle_start) begin
							s_next.cbc_act = 1'b0;
						end
					end
					CBC_THR: begin
						if (!cbc_cmp) begin
							s_next.cbc_act = 1'b0;
						end
					end
					CBC_CNT: begin
						if (pwm_cycle_start) begin
							if (s_reg.cbc_cnt == 3'h0) begin
								s_next.cbc_act = 1'b0;
							end else begin
								s_next.cbc_cnt = s_reg.cbc_cnt - 3'h1;
							end
						end
					end
					default: begin
						s_next.cbc_act = 1'b0;
					end
				endcase
			end
		end else if (cbc_auto && cbc_cmp) begin
			s_next.cbc_act = 1'b1;
			s_next.cbc_cnt = s_reg.cfg[F_CBC_HOLD +: 3];
		end
		s_next.cbc_pin = s_next.cbc_act && !cbc_mode[0];
		if (s_reg.clr && !cbc_cmp) begin
			s_next.cbc_rep = 1'b0;
		end
		if (cbc_mode == CBC_REPORT && cbc_cmp) begin
			s_next.cbc_rep = 1'b1;
		end
		// ---------------- stall current limit ----------------
		if (s_reg.lock_retry) begin
			if (s_reg.lock_timer <= 32'h1) begin
				s_next.lock_retry = 1'b0;
				s_next.lock_act = 1'b0;
				s_next.lock_flag = 1'b0;
			end else begin
				s_next.lock_timer = s_reg.lock_timer - 32'h1;
			end
		end else if (s_reg.clr && !lock_det) begin
			s_next.lock_act = 1'b0;
			s_next.lock_flag = 1'b0;
		end
		if (lock_det && !s_reg.lock_act) begin
			if (lck_mode[3:2] == LCK_LATCH) begin
				s_next.lock_act = 1'b1;
				s_next.lock_flag = 1'b1;
			end else if (lck_mode[3:2] == LCK_AUTO && !s_reg.lock_retry) begin
				s_next.lock_act = 1'b1;
				s_next.lock_retry = 1'b1;
				s_next.lock_flag = 1'b1;
				s_next.lock_timer = fm_steps(s_reg.cfg[F_STALL_RETRY_TIME +: 3],
					STALL_RETRY_TIME_CYC);
			end else if (lck_mode == LCK_REPORT) begin
				s_next.lock_flag = 1'b1;
			end
		end
		// ---------------- outputs ----------------
		s_next.bridge = BR_RUN;
		if (s_next.lock_act) begin
			unique case (lck_mode[1:0])
				2'h0: s_next.bridge = BR_OFF;
				2'h1: s_next.bridge = BR_RECIRC;
				2'h2: s_next.bridge = BR_HS_BRAKE;
				2'h3: s_next.bridge = BR_LS_BRAKE;
			endcase
		end else if (s_next.cbc_act) begin
			s_next.bridge = BR_RECIRC;
		end
		if (pump_uv || ov_now || s_next.oc_latch || s_next.oc_hold) begin
			s_next.bridge = BR_OFF;
		end
		s_next.fault_n = !(pump_uv || ov_now || s_next.oc_latch ||
			s_next.oc_hold || s_next.cbc_pin || s_next.lock_act);
		s_next.rst_req = 1'b0;
		s_next.pump_off = pump_uv || ov_now;
		s_next.buck_off = 1'b0;
		// supply loss overrides everything; logic held in its reset state
		sys_down = motor_supply_undervolt_s || avdd_s || buck_uv_s || buck_oc_det;
		if (sys_down) begin
			s_next = ST_RESET;
			s_next.rst_req = 1'b1;
			s_next.pump_off = 1'b1;
			s_next.buck_off = buck_uv_s;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= ST_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// level codes for the analog comparators, all registered
	logic [3:0] cbc_lvl_reg;
	logic [3:0] cbc_lvl_next;

	assign cbc_lvl_next = open_loop ? s_reg.cfg[F_OL_LVL +: 4] :
		s_reg.cfg[F_CBC_LVL +: 4];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cbc_lvl_reg <= 4'h0;
		end else begin
			cbc_lvl_reg <= cbc_lvl_next;
		end
	end

	assign bridge_state = s_reg.bridge;
	assign fault_pin_n = s_reg.fault_n;
	assign dev_reset_req = s_reg.rst_req;
	assign pump_disable = s_reg.pump_off;
	assign buck_disable = s_reg.buck_off;
	assign overvolt_level_sel = s_reg.ctrl[C_OVERVOLT_LEVEL_SEL];
	assign overcurrent_level = s_reg.cfg[F_OC_LVL +: 4];
	assign cycle_limit_level = cbc_lvl_reg;
	assign s_axi_awready = s_reg.awready;
	assign s_axi_wready = s_reg.wready;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = s_reg.arready;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;
endmodule

// ===== sim/fm_fault_mgr_properties.sv
`timescale 1ns/100ps
module fm_fault_mgr_properties
	import fm_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// event pins
	input wire logic motor_supply_undervolt,
	input wire logic analog_rail_undervolt,
	input wire logic buck_undervolt,
	input wire logic buck_overcurrent,
	input wire logic pump_undervolt_event,
	// power stage outputs
	input wire fm_bridge_e bridge_state,
	input wire logic fault_pin_n,
	input wire logic dev_reset_req,
	input wire logic pump_disable,
	input wire logic buck_disable,
	input wire logic overvolt_level_sel,
	// bus
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_rvalid
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// helpers and properties
	// ------------------------------------------------------------
	logic [5:0] boc_cnt;
	logic sel_seen;
	logic ctrl_take;
	assign ctrl_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready && s_axi_awaddr == {27'h0, ADDR_CTRL};
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			boc_cnt <= 6'h00;
			sel_seen <= 1'b0;
		end else begin
			boc_cnt <= !buck_overcurrent ? 6'h00 :
				boc_cnt + {5'h00, boc_cnt != 6'h3f};
			if (ctrl_take) begin
				sel_seen <= s_axi_wdata[1];
			end
		end
	end
	// pins pass a synchroniser, so allow seven held samples
	sequence s_held(logic x);
		$rose(x) ##1 x [*7];
	endsequence
	sequence s_in_reset;
		dev_reset_req ##1 dev_reset_req;
	endsequence
	property p_uv_off;
		s_held(motor_supply_undervolt) |-> dev_reset_req && pump_disable &&
			bridge_state == BR_OFF;
	endproperty
	property p_avdd_off;
		s_held(analog_rail_undervolt) |-> dev_reset_req && pump_disable &&
			bridge_state == BR_OFF;
	endproperty
	property p_buck_uv;
		s_held(buck_undervolt) |-> dev_reset_req && buck_disable;
	endproperty
	property p_buck_oc;
		boc_cnt == 6'h3c |-> dev_reset_req;
	endproperty
	property p_pump_off;
		s_held(pump_undervolt_event) |-> bridge_state == BR_OFF && !fault_pin_n;
	endproperty
	property p_lvl_sel;
		ctrl_take |-> ##4 overvolt_level_sel == sel_seen;
	endproperty
	property p_dev_off;
		s_in_reset |-> bridge_state == BR_OFF;
	endproperty
	property p_dev_bus;
		s_in_reset |-> !s_axi_bvalid && !s_axi_rvalid;
	endproperty
	a_uv_off: assert property (p_uv_off)
		else $error("supply loss left device running");
	a_avdd_off: assert property (p_avdd_off)
		else $error("analog rail loss left device running");
	a_buck_uv: assert property (p_buck_uv)
		else $error("buck loss left switches on");
	a_buck_oc: assert property (p_buck_oc)
		else $error("buck overcurrent gave no reset");
	a_pump_off: assert property (p_pump_off)
		else $error("pump loss left bridge on");
	a_lvl_sel: assert property (p_lvl_sel)
		else $error("trip level select not taken");
	a_dev_off: assert property (p_dev_off)
		else $error("bridge driven during reset");
	a_dev_bus: assert property (p_dev_bus)
		else $error("bus answered during reset");
endmodule
bind fm_fault_mgr fm_fault_mgr_properties fm_fault_mgr_properties_i (.*);

// ===== sim/fm_stage_model.sv
`timescale 1ns/100ps
module fm_stage_model
	import fm_pkg::*;
#(
	parameter int PWM_CYC = 400
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// device outputs
	input wire fm_bridge_e bridge_state,
	input wire logic [3:0] cycle_limit_level,
	// phase current asked for by the bench
	input wire logic [11:0] load,
	// sense path and pwm timing
	output logic [11:0] sense_amp_output,
	output logic sense_valid,
	output logic cycle_limit_cmp,
	output logic pwm_cycle_start
);
	int cnt;
	// current drops at once when the bridge leaves BR_RUN
	assign cycle_limit_cmp = bridge_state == BR_RUN &&
		load[11:8] > cycle_limit_level;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			pwm_cycle_start <= 1'b0;
			sense_valid <= 1'b0;
			sense_amp_output <= 12'h000;
		end else begin
			cnt <= cnt == PWM_CYC - 1 ? 0 : cnt + 1;
			pwm_cycle_start <= cnt == 0;
			sense_valid <= cnt[1:0] == 2'h3;
			// no held value between samples, so stale reads show up
			sense_amp_output <= cnt[1:0] == 2'h3 ? load : ~load;
		end
	end
endmodule

// ===== sim/test_fm_fault_mgr.sv
`timescale 1ns/100ps
module test_fm_fault_mgr
	import fm_pkg::*;
;
	logic clk_sys = 1'b0, rst_n = 1'b0, open_loop = 1'b0;
	logic motor_supply_undervolt = 1'b0, analog_rail_undervolt = 1'b0;
	logic buck_undervolt = 1'b0, buck_overcurrent = 1'b0;
	logic pump_undervolt_event = 1'b0, overvolt_low_trip = 1'b0;
	logic overvolt_high_trip = 1'b0, s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [5:0] fet_overcurrent_cmp = 6'h00;
	logic [11:0] load = 12'h000;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
	logic [31:0] s_axi_araddr = 32'h0;
	logic cycle_limit_cmp, pwm_cycle_start, sense_valid, fault_pin_n;
	logic dev_reset_req, pump_disable, buck_disable, overvolt_level_sel;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] overcurrent_level, cycle_limit_level;
	logic [11:0] sense_amp_output;
	logic [31:0] s_axi_rdata, rd;
	fm_bridge_e bridge_state;
	int mismatches = 0, total_checks = 0;
	fm_fault_mgr #(.OC_RETRY_CYC(32'h64), .STALL_RETRY_TIME_CYC(32'hc8))
		fm_fault_mgr_i (.*);
	fm_stage_model fm_stage_model_i (.*);
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	task automatic axw(input logic [31:0] a, d, input logic [1:0] er);
		int n = 0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		s_axi_bready <= 1'b0;
		chk("bvalid", 32'h1, 32'(s_axi_bvalid));
		chk("bresp", 32'(er), 32'(s_axi_bresp));
	endtask
	task automatic axr(input logic [31:0] a, input logic [1:0] er,
		output logic [31:0] d);
		int n = 0;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		s_axi_rready <= 1'b0;
		chk("rvalid", 32'h1, 32'(s_axi_rvalid));
		d = s_axi_rdata;
		chk("rresp", 32'(er), 32'(s_axi_rresp));
	endtask
	task automatic ev(input int k, input logic on);
		@(posedge clk_sys);
		case (k)
			0: pump_undervolt_event <= on;
			1: fet_overcurrent_cmp <= {5'h00, on};
			2: load <= on ? 12'h800 : 12'h000;
			3: load <= on ? 12'hfff : 12'h000;
			default: overvolt_low_trip <= on;
		endcase
	endtask
	task automatic sync_pwm;
		repeat (500) begin
			@(posedge clk_sys);
			if (pwm_cycle_start) break;
		end
	endtask
	// event, check, release, check, clear after reading status
	task automatic cs(input logic [31:0] c, input int k, input fm_bridge_e b1,
		input logic p1, input logic [15:0] s1, input fm_bridge_e b2,
		input logic [15:0] s2);
		axw(32'(ADDR_CTRL), c, AXI_OKAY);
		sync_pwm();
		ev(k, 1'b1);
		repeat (k == 2 ? 400 : 40) begin
			@(posedge clk_sys);
			if (bridge_state !== BR_RUN || fault_pin_n !== 1'b1) break;
		end
		repeat (3) @(posedge clk_sys);
		chk("bridge", 32'(b1), 32'(bridge_state));
		chk("fault_pin_n", 32'(p1), 32'(fault_pin_n));
		axr(32'(ADDR_STAT), AXI_OKAY, rd);
		chk("stat", 32'(s1), rd);
		ev(k, 1'b0);
		repeat (500) @(posedge clk_sys);
		chk("bridge", 32'(b2), 32'(bridge_state));
		axr(32'(ADDR_STAT), AXI_OKAY, rd);
		chk("stat", 32'(s2), rd & 32'h1ffc);
		axw(32'(ADDR_CTRL), c | 32'h1000, AXI_OKAY);
		repeat (10) @(posedge clk_sys);
		chk("bridge", 32'(BR_RUN), 32'(bridge_state));
		axr(32'(ADDR_STAT), AXI_OKAY, rd);
		chk("stat", 32'h0, rd);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		axr(32'(ADDR_CTRL), AXI_OKAY, rd);
		chk("ctrl", 32'h0, rd);
		axr(32'(ADDR_LVL), AXI_OKAY, rd);
		chk("lvl", 32'hfff, rd);
		axr(32'h10, AXI_SLVERR, rd);
		axw(32'h10, 32'hffffffff, AXI_SLVERR);
		axw(32'(ADDR_STAT), 32'hffffffff, AXI_OKAY);
		axw(32'(ADDR_CFG), 32'hffffffff, AXI_OKAY);
		axr(32'(ADDR_CFG), AXI_OKAY, rd);
		chk("cfg", 32'h00ffffff, rd);
		chk("overcurrent_level", 32'hf, 32'(overcurrent_level));
		axw(32'(ADDR_CFG), 32'h00000700, AXI_OKAY);
		axw(32'(ADDR_LVL), 32'h00000100, AXI_OKAY);
		chk("cycle_limit_level", 32'h7, 32'(cycle_limit_level));
		open_loop <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk("cycle_limit_level", 32'h0, 32'(cycle_limit_level));
		open_loop <= 1'b0;
		cs(32'h970, 0, BR_OFF, 1'b0, 16'h5, BR_RUN, 16'h4);
		cs(32'h971, 4, BR_OFF, 1'b0, 16'h9, BR_RUN, 16'h8);
		cs(32'h973, 4, BR_RUN, 1'b1, 16'h0, BR_RUN, 16'h0);
		cs(32'h970, 1, BR_OFF, 1'b0, 16'h31, BR_OFF, 16'h30);
		cs(32'h974, 1, BR_OFF, 1'b0, 16'h31, BR_RUN, 16'h30);
		cs(32'h978, 1, BR_RUN, 1'b1, 16'h31, BR_RUN, 16'h30);
		cs(32'h97c, 1, BR_RUN, 1'b1, 16'h0, BR_RUN, 16'h0);
		cs(32'h900, 3, BR_RECIRC, 1'b0, 16'h802, BR_RUN, 16'h0);
		cs(32'h910, 3, BR_RECIRC, 1'b1, 16'h800, BR_RUN, 16'h0);
		axw(32'(ADDR_CTRL), 32'h920, AXI_OKAY);
		sync_pwm();
		ev(3, 1'b1);
		repeat (20) begin
			@(posedge clk_sys);
			if (bridge_state === BR_RECIRC) break;
		end
		chk("fault_pin_n", 32'h0, 32'(fault_pin_n));
		repeat (20) begin
			@(posedge clk_sys);
			if (bridge_state === BR_RUN) break;
		end
		chk("bridge", 32'(BR_RUN), 32'(bridge_state));
		ev(3, 1'b0);
		cs(32'h940, 3, BR_RECIRC, 1'b0, 16'h802, BR_RUN, 16'h0);
		cs(32'h960, 3, BR_RUN, 1'b1, 16'h802, BR_RUN, 16'h800);
		cs(32'h970, 3, BR_RUN, 1'b1, 16'h0, BR_RUN, 16'h0);
		cs(32'h070, 2, BR_OFF, 1'b0, 16'h1002, BR_OFF, 16'h1000);
		cs(32'h170, 2, BR_RECIRC, 1'b0, 16'h1002, BR_RECIRC, 16'h1000);
		cs(32'h270, 2, BR_HS_BRAKE, 1'b0, 16'h1002, BR_HS_BRAKE, 16'h1000);
		cs(32'h370, 2, BR_LS_BRAKE, 1'b0, 16'h1002, BR_LS_BRAKE, 16'h1000);
		cs(32'h570, 2, BR_RECIRC, 1'b0, 16'h1002, BR_RUN, 16'h0);
		cs(32'h870, 2, BR_RUN, 1'b1, 16'h1002, BR_RUN, 16'h1000);
		cs(32'h970, 2, BR_RUN, 1'b1, 16'h0, BR_RUN, 16'h0);
		for (int i = 0; i < 4; i++) begin
			axw(32'(ADDR_CTRL), 32'h973, AXI_OKAY);
			{motor_supply_undervolt, analog_rail_undervolt, buck_undervolt,
				buck_overcurrent} <= 4'h8 >> i;
			repeat (80) @(posedge clk_sys);
			chk("reset_req", 32'h1, 32'(dev_reset_req));
			{motor_supply_undervolt, analog_rail_undervolt, buck_undervolt,
				buck_overcurrent} <= 4'h0;
			repeat (20) @(posedge clk_sys);
			axr(32'(ADDR_CTRL), AXI_OKAY, rd);
			chk("ctrl", 32'h0, rd);
		end
		results();
	end
	initial begin
		repeat (60000) @(posedge clk_sys);
		mismatches++;
		results();
	end
endmodule
